/* rtl/ext_bus_pkg.sv */
// Purpose: constants and types for the external byte bus controller
// Assumes: SYS_CLK_I is the host bus clock, 20 MHz
// Notes: every interval on the byte bus is a whole number of clock cycles
//
// What this block does
// - byte, half-word, word host access become 1, 2, 4 byte cycles, ascending
// - with wait_for_blank set, cycles start only in back porch or sync
// - byte cycles stay allowed while digital video output is enabled
// - with video output on, data lines carry video bytes while the sequencer is idle
// - test state drives the selected test byte; bus unused in test state
// - a 4-bit external address gives a 16-byte space from host address
// - peripheral wait low stretches the strobe; access completes after release
// - interrupt input edge of chosen polarity raises host irq when enabled
// - write strobe low at least four clocks less 3 ns
// - read strobe low at least four clocks less 3 ns
// - address and write data stable two clocks less 3 ns before strobe
// - address and write data held two clocks less 3 ns after strobe
// - both strobes high three clocks less 3 ns between byte cycles
// - peripheral reset during hardware reset and external reset command only
// - all byte bus timing counted on the host bus clock
package ext_bus_pkg;

   // ----------------------------------------------------------------
   // clock and interval times
   // ----------------------------------------------------------------
   localparam int CLK_NS = 50;
   localparam int ALLOW_NS = 3;
   localparam int SETUP_NS = 2 * CLK_NS - ALLOW_NS;
   localparam int STROBE_NS = 4 * CLK_NS - ALLOW_NS;
   localparam int HOLD_NS = 2 * CLK_NS - ALLOW_NS;
   localparam int PRECH_NS = 3 * CLK_NS - ALLOW_NS;
   // least times round up to whole cycles
   localparam logic [3:0] SETUP_CYC = 4'((SETUP_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [3:0] STROBE_CYC = 4'((STROBE_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [3:0] HOLD_CYC = 4'((HOLD_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [3:0] PRECH_CYC = 4'((PRECH_NS + CLK_NS - 1) / CLK_NS);

   // ----------------------------------------------------------------
   // register map (word offsets are byte addresses)
   // ----------------------------------------------------------------
   localparam logic [3:0] EXT_BUS_CONTROL_OFS = 4'h0;
   localparam logic [3:0] INTERRUPT_ENABLE_OFS = 4'h4;
   localparam logic [3:0] STATUS_OFS = 4'h8;
   localparam int CTL_WAIT_BLANK_BIT = 0;
   localparam int CTL_IRQ_POL_BIT = 1;
   localparam int CTL_EXT_RESET_BIT = 2;
   localparam int IEN_EXT_BIT = 0;
   localparam int STAT_PEND_BIT = 0;
   localparam int STAT_BUSY_BIT = 1;
   localparam int STAT_WAIT_BIT = 2;
   localparam logic [2:0] CTL_RESET = 3'h0;
   localparam logic IEN_RESET = 1'b0;

   // ----------------------------------------------------------------
   // host access sizes and sequencer states
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      SIZE_BYTE = 2'h0,
      SIZE_HALF = 2'h1,
      SIZE_WORD = 2'h2
   } access_size_t;

   typedef enum logic [2:0] {
      ST_IDLE = 3'h5,
      ST_SETUP = 3'h3,
      ST_STROBE = 3'h2,
      ST_HOLD = 3'h0,
      ST_PRECH = 3'h1
   } bus_state_t;

   function automatic logic [2:0] byte_count(input logic [1:0] size);
      byte_count = (size == SIZE_WORD) ? 3'h4 :
                   (size == SIZE_HALF) ? 3'h2 : 3'h1;
   endfunction

endpackage

/* rtl/interval_timer.sv */
// Purpose: down counter that times one phase of a byte cycle
// Assumes: load and count share the system clock
// Notes: done is high while the count stands at zero
`timescale 1ns/1ps
module interval_timer
   import ext_bus_pkg::*;
(
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // control
   input wire logic load_i,
   input wire logic [3:0] count_i,
   // status
   output logic done_o
);

   logic [3:0] cnt_q;
   logic [3:0] cnt_d;

   always_comb begin
      cnt_d = cnt_q;
      if (load_i) begin
         cnt_d = count_i;
      end else if (cnt_q != 4'h0) begin
         cnt_d = cnt_q - 4'h1;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cnt_q <= 4'h0;
      end else begin
         cnt_q <= cnt_d;
      end
   end

   assign done_o = (cnt_q == 4'h0);

endmodule

/* rtl/irq_edge_catch.sv */
// Purpose: edge detector with selectable polarity and sticky pending flag
// Assumes: the interrupt input is synchronous to the clock
// Notes: a new edge in the clearing cycle keeps the flag set
`timescale 1ns/1ps
module irq_edge_catch
   import ext_bus_pkg::*;
(
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // input and control
   input wire logic irq_i,
   input wire logic falling_i,
   input wire logic clear_i,
   // status
   output logic pend_o
);

   logic last_q;
   logic last_d;
   logic pend_q;
   logic pend_d;
   logic edge_seen;

   always_comb begin
      last_d = irq_i;
      edge_seen = falling_i ? (last_q & ~irq_i) : (~last_q & irq_i);
      pend_d = edge_seen | (pend_q & ~clear_i);
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         last_q <= 1'b0;
         pend_q <= 1'b0;
      end else begin
         last_q <= last_d;
         pend_q <= pend_d;
      end
   end

   assign pend_o = pend_q;

endmodule

/* rtl/ext_byte_bus.sv */
// Purpose: splits host accesses into strobed byte cycles on the external bus
// Assumes: SYS_CLK_I is the host bus clock; all inputs synchronous to it
// Notes: pins are registered from the next state, so they change in the same cycle as the sequencer state
//
// The register addresses and the plain strobed port are this design's own decisions.
`timescale 1ns/1ps
module ext_byte_bus
   import ext_bus_pkg::*;
(
   // clock and resets
   input wire logic SYS_CLK_I,
   input wire logic RST_I,
   input wire logic SOFT_CORE_RST_I,
   // register port
   input wire logic [3:0] REG_ADDR_I,
   input wire logic [31:0] REG_WDATA_I,
   input wire logic REG_WR_I,
   input wire logic REG_RD_I,
   output logic [31:0] REG_RDATA_O,
   // host access port
   input wire logic HOST_REQ_I,
   input wire logic HOST_WRITE_I,
   input wire logic [1:0] HOST_SIZE_I,
   input wire logic [3:0] HOST_ADDR_I,
   input wire logic [31:0] HOST_WDATA_I,
   output logic HOST_BUSY_O,
   output logic HOST_DONE_O,
   output logic [31:0] HOST_RDATA_O,
   output logic HOST_IRQ_O,
   // display timing, video and test
   input wire logic HBLANK_PORCH_SYNC_I,
   input wire logic VIDEO_OUT_EN_I,
   input wire logic [7:0] VIDEO_BYTE_I,
   input wire logic FACTORY_TEST_STATE_I,
   input wire logic [7:0] TEST_SEL_BYTE_I,
   // external byte bus pins
   input wire logic [7:0] EXT_DATA_LINES_I,
   output logic [7:0] EXT_DATA_LINES_O,
   output logic EXT_DATA_LINES_OE_N_O,
   output logic [3:0] EXT_ADDRESS_LINES_O,
   output logic EXT_WRITE_STROBE_N_O,
   output logic EXT_READ_STROBE_N_O,
   input wire logic EXT_WAIT_N_I,
   input wire logic EXT_IRQ_IN_I,
   output logic PERIPHERAL_RESET_N_O
);

   // ----------------------------------------------------------------
   // resets
   // ----------------------------------------------------------------
   // soft core reset clears the block but leaves the peripheral reset alone
   logic core_rst;
   assign core_rst = RST_I | SOFT_CORE_RST_I;

   // ----------------------------------------------------------------
   // register file
   // ----------------------------------------------------------------
   logic [2:0] ctl_q;
   logic [2:0] ctl_d;
   logic ien_q;
   logic ien_d;
   logic [31:0] rdata_q;
   logic [31:0] rdata_d;
   logic irq_pend;
   logic irq_clear;
   logic prst_n_q;
   logic prst_n_d;
   bus_state_t state_q;

   always_comb begin
      ctl_d = ctl_q;
      ien_d = ien_q;
      rdata_d = 32'h0;
      irq_clear = 1'b0;
      if (REG_WR_I) begin
         unique case (REG_ADDR_I)
            EXT_BUS_CONTROL_OFS: ctl_d = REG_WDATA_I[2:0];
            INTERRUPT_ENABLE_OFS: ien_d = REG_WDATA_I[IEN_EXT_BIT];
            STATUS_OFS: irq_clear = REG_WDATA_I[STAT_PEND_BIT];
            default: ctl_d = ctl_q;
         endcase
      end
      if (REG_RD_I) begin
         unique case (REG_ADDR_I)
            EXT_BUS_CONTROL_OFS: rdata_d = {29'h0, ctl_q};
            INTERRUPT_ENABLE_OFS: rdata_d = {31'h0, ien_q};
            STATUS_OFS: begin
               rdata_d[STAT_PEND_BIT] = irq_pend;
               rdata_d[STAT_BUSY_BIT] = (state_q != ST_IDLE);
               rdata_d[STAT_WAIT_BIT] = ~EXT_WAIT_N_I;
            end
            default: rdata_d = 32'h0;
         endcase
      end
      // peripheral reset follows hardware reset and the external command
      prst_n_d = ~ctl_d[CTL_EXT_RESET_BIT];
   end

   always_ff @(posedge SYS_CLK_I) begin
      if (core_rst) begin
         ctl_q <= CTL_RESET;
         ien_q <= IEN_RESET;
         rdata_q <= 32'h0;
      end else begin
         ctl_q <= ctl_d;
         ien_q <= ien_d;
         rdata_q <= rdata_d;
      end
   end

   // plain soft reset must not pulse the peripheral reset
   always_ff @(posedge SYS_CLK_I) begin
      if (RST_I) begin
         prst_n_q <= 1'b0;
      end else if (SOFT_CORE_RST_I) begin
         prst_n_q <= prst_n_q;
      end else begin
         prst_n_q <= prst_n_d;
      end
   end

   assign REG_RDATA_O = rdata_q;
   assign PERIPHERAL_RESET_N_O = prst_n_q;

   // ----------------------------------------------------------------
   // external interrupt
   // ----------------------------------------------------------------
   irq_edge_catch i_irq_edge_catch (
      .clk_i(SYS_CLK_I),
      .rst_i(core_rst),
      .irq_i(EXT_IRQ_IN_I),
      .falling_i(ctl_q[CTL_IRQ_POL_BIT]),
      .clear_i(irq_clear),
      .pend_o(irq_pend)
   );
   assign HOST_IRQ_O = irq_pend & ien_q;

   // ----------------------------------------------------------------
   // byte cycle sequencer
   // ----------------------------------------------------------------
   bus_state_t state_d;
   logic write_q;
   logic write_d;
   logic [3:0] base_q;
   logic [3:0] base_d;
   logic [2:0] total_q;
   logic [2:0] total_d;
   logic [1:0] idx_q;
   logic [1:0] idx_d;
   logic [31:0] data_q;
   logic [31:0] data_d;
   logic done_q;
   logic done_d;
   logic tmr_load;
   logic [3:0] tmr_count;
   logic tmr_done;
   logic start_ok;

   interval_timer i_interval_timer (
      .clk_i(SYS_CLK_I),
      .rst_i(core_rst),
      .load_i(tmr_load),
      .count_i(tmr_count),
      .done_o(tmr_done)
   );

   // blanking gate and test state both hold off a new byte cycle;
   // video output does not, the sequencer takes the lines over
   always_comb begin
      start_ok = ~FACTORY_TEST_STATE_I &
                 (~ctl_q[CTL_WAIT_BLANK_BIT] | HBLANK_PORCH_SYNC_I);
   end

   always_comb begin
      state_d = state_q;
      write_d = write_q;
      base_d = base_q;
      total_d = total_q;
      idx_d = idx_q;
      data_d = data_q;
      done_d = 1'b0;
      tmr_load = 1'b0;
      tmr_count = 4'h0;
      unique case (state_q)
         ST_IDLE: begin
            if (HOST_REQ_I) begin
               write_d = HOST_WRITE_I;
               base_d = HOST_ADDR_I;
               total_d = byte_count(HOST_SIZE_I);
               idx_d = 2'h0;
               data_d = HOST_WRITE_I ? HOST_WDATA_I : 32'h0;
               state_d = ST_PRECH;
            end
         end
         ST_SETUP: begin
            if (tmr_done) begin
               state_d = ST_STROBE;
               tmr_load = 1'b1;
               tmr_count = STROBE_CYC - 4'h1;
            end
         end
         ST_STROBE: begin
            // minimum width first, then as long as the peripheral waits
            if (tmr_done && EXT_WAIT_N_I) begin
               if (!write_q) begin
                  data_d[8*idx_q +: 8] = EXT_DATA_LINES_I;
               end
               state_d = ST_HOLD;
               tmr_load = 1'b1;
               tmr_count = HOLD_CYC - 4'h1;
            end
         end
         ST_HOLD: begin
            if (tmr_done) begin
               state_d = ST_PRECH;
               tmr_load = 1'b1;
               tmr_count = PRECH_CYC - 4'h1;
               idx_d = idx_q + 2'h1;
               if ({1'b0, idx_q} + 3'h1 == total_q) begin
                  done_d = 1'b1;
                  state_d = ST_IDLE;
               end
            end
         end
         ST_PRECH: begin
            // entry from idle waits out whatever precharge the timer still holds
            if (tmr_done && start_ok) begin
               state_d = ST_SETUP;
               tmr_load = 1'b1;
               tmr_count = SETUP_CYC - 4'h1;
            end
         end
      endcase
   end

   always_ff @(posedge SYS_CLK_I) begin
      if (core_rst) begin
         state_q <= ST_IDLE;
         write_q <= 1'b0;
         base_q <= 4'h0;
         total_q <= 3'h1;
         idx_q <= 2'h0;
         data_q <= 32'h0;
         done_q <= 1'b0;
      end else begin
         state_q <= state_d;
         write_q <= write_d;
         base_q <= base_d;
         total_q <= total_d;
         idx_q <= idx_d;
         data_q <= data_d;
         done_q <= done_d;
      end
   end

   // host stays pending until the last byte cycle has finished
   assign HOST_BUSY_O = (state_q != ST_IDLE);
   assign HOST_DONE_O = done_q;
   assign HOST_RDATA_O = data_q;

   // ----------------------------------------------------------------
   // pin drivers
   // ----------------------------------------------------------------
   logic [7:0] dl_q;
   logic [7:0] dl_d;
   logic dl_oe_n_q;
   logic dl_oe_n_d;
   logic [3:0] al_q;
   logic [3:0] al_d;
   logic wr_n_q;
   logic wr_n_d;
   logic rd_n_q;
   logic rd_n_d;
   logic in_cycle;

   // pins follow next state, so setup, strobe and hold line up exactly
   always_comb begin
      in_cycle = (state_d == ST_SETUP) || (state_d == ST_STROBE) ||
                 (state_d == ST_HOLD);
      al_d = al_q;
      if (in_cycle) begin
         al_d = base_q + {2'h0, idx_q};
      end
      wr_n_d = ~((state_d == ST_STROBE) & write_q);
      rd_n_d = ~((state_d == ST_STROBE) & ~write_q);
      dl_d = 8'h0;
      dl_oe_n_d = 1'b1;
      if (FACTORY_TEST_STATE_I) begin
         dl_d = TEST_SEL_BYTE_I;
         dl_oe_n_d = 1'b0;
      end else if (in_cycle && write_q) begin
         dl_d = data_q[8*idx_q +: 8];
         dl_oe_n_d = 1'b0;
      end else if (state_d == ST_IDLE && VIDEO_OUT_EN_I) begin
         dl_d = VIDEO_BYTE_I;
         dl_oe_n_d = 1'b0;
      end
   end

   always_ff @(posedge SYS_CLK_I) begin
      if (core_rst) begin
         dl_q <= 8'h0;
         dl_oe_n_q <= 1'b1;
         al_q <= 4'h0;
         wr_n_q <= 1'b1;
         rd_n_q <= 1'b1;
      end else begin
         dl_q <= dl_d;
         dl_oe_n_q <= dl_oe_n_d;
         al_q <= al_d;
         wr_n_q <= wr_n_d;
         rd_n_q <= rd_n_d;
      end
   end

   assign EXT_DATA_LINES_O = dl_q;
   assign EXT_DATA_LINES_OE_N_O = dl_oe_n_q;
   assign EXT_ADDRESS_LINES_O = al_q;
   assign EXT_WRITE_STROBE_N_O = wr_n_q;
   assign EXT_READ_STROBE_N_O = rd_n_q;

endmodule

/* sim/ext_byte_bus_sva.sv */
// Purpose: pin timing checks for the byte bus controller
// Assumes: pins registered, one clock
// Notes: bound to the top module below
`timescale 1ns/1ps
module ext_byte_bus_sva (
   // clock and resets
   input wire logic SYS_CLK_I,
   input wire logic RST_I,
   input wire logic SOFT_CORE_RST_I,
   // host side
   input wire logic HOST_BUSY_O,
   input wire logic HOST_DONE_O,
   input wire logic VIDEO_OUT_EN_I,
   input wire logic [7:0] VIDEO_BYTE_I,
   input wire logic FACTORY_TEST_STATE_I,
   input wire logic [7:0] TEST_SEL_BYTE_I,
   // pins
   input wire logic [7:0] EXT_DATA_LINES_O,
   input wire logic EXT_DATA_LINES_OE_N_O,
   input wire logic [3:0] EXT_ADDRESS_LINES_O,
   input wire logic EXT_WRITE_STROBE_N_O,
   input wire logic EXT_READ_STROBE_N_O,
   input wire logic EXT_WAIT_N_I,
   input wire logic PERIPHERAL_RESET_N_O
);
   // ----------------
   // helpers
   // ----------------
   logic calm_q;
   wire logic str_n = EXT_WRITE_STROBE_N_O & EXT_READ_STROBE_N_O;
   // pins change with the sequencer state; idle must still have held two samples
   always_ff @(posedge SYS_CLK_I) begin
      calm_q <= !(RST_I | SOFT_CORE_RST_I | HOST_BUSY_O | HOST_DONE_O);
   end
   default clocking cb @(posedge SYS_CLK_I); endclocking
   default disable iff (RST_I || SOFT_CORE_RST_I);
   sequence s_prech;
      str_n [*3];
   endsequence
   sequence s_wr_held;
      $stable(EXT_ADDRESS_LINES_O) && $stable(EXT_DATA_LINES_O)
         && !EXT_DATA_LINES_OE_N_O;
   endsequence
   // ----------------
   // properties
   // ----------------
   property p_wr_width;
      $fell(EXT_WRITE_STROBE_N_O) |-> !EXT_WRITE_STROBE_N_O [*4];
   endproperty
   a_wr_width: assert property (p_wr_width) else $error("short write");
   property p_rd_width;
      $fell(EXT_READ_STROBE_N_O) |-> !EXT_READ_STROBE_N_O [*4];
   endproperty
   a_rd_width: assert property (p_rd_width) else $error("short read");
   property p_setup;
      $fell(str_n) |-> $stable(EXT_ADDRESS_LINES_O)
         && EXT_ADDRESS_LINES_O == $past(EXT_ADDRESS_LINES_O, 2)
         && (EXT_WRITE_STROBE_N_O || (!$past(EXT_DATA_LINES_OE_N_O, 2)
         && EXT_DATA_LINES_O == $past(EXT_DATA_LINES_O, 2)));
   endproperty
   a_setup: assert property (p_setup) else $error("setup short");
   property p_hold;
      $rose(EXT_WRITE_STROBE_N_O) |-> s_wr_held ##1 s_wr_held;
   endproperty
   a_hold: assert property (p_hold) else $error("hold short");
   property p_prech;
      $rose(str_n) |-> s_prech;
   endproperty
   a_prech: assert property (p_prech) else $error("precharge short");
   property p_rd_float;
      !EXT_READ_STROBE_N_O |-> EXT_DATA_LINES_OE_N_O;
   endproperty
   a_rd_float: assert property (p_rd_float) else $error("read drive");
   property p_wait;
      $rose(str_n) |-> $past(EXT_WAIT_N_I);
   endproperty
   a_wait: assert property (p_wait) else $error("wait ignored");
   property p_test;
      calm_q && $past(calm_q) && $past(FACTORY_TEST_STATE_I)
         |-> !EXT_DATA_LINES_OE_N_O
         && EXT_DATA_LINES_O == $past(TEST_SEL_BYTE_I);
   endproperty
   a_test: assert property (p_test) else $error("test byte");
   property p_video;
      // not busy now: the sequencer chose idle when these pins launched
      calm_q && !HOST_BUSY_O && $past(VIDEO_OUT_EN_I)
         && !$past(FACTORY_TEST_STATE_I) |-> !EXT_DATA_LINES_OE_N_O
         && EXT_DATA_LINES_O == $past(VIDEO_BYTE_I);
   endproperty
   a_video: assert property (p_video) else $error("video byte");
   property p_prst_hw;
      disable iff (1'b0) RST_I |=> !PERIPHERAL_RESET_N_O;
   endproperty
   a_prst_hw: assert property (p_prst_hw) else $error("no reset");
   property p_prst_sw;
      disable iff (RST_I) SOFT_CORE_RST_I |=> $stable(PERIPHERAL_RESET_N_O);
   endproperty
   a_prst_sw: assert property (p_prst_sw) else $error("soft reset");
endmodule
bind ext_byte_bus ext_byte_bus_sva i_sva (
   .SYS_CLK_I(SYS_CLK_I), .RST_I(RST_I), .SOFT_CORE_RST_I(SOFT_CORE_RST_I),
   .HOST_BUSY_O(HOST_BUSY_O), .HOST_DONE_O(HOST_DONE_O),
   .VIDEO_OUT_EN_I(VIDEO_OUT_EN_I), .VIDEO_BYTE_I(VIDEO_BYTE_I),
   .FACTORY_TEST_STATE_I(FACTORY_TEST_STATE_I),
   .TEST_SEL_BYTE_I(TEST_SEL_BYTE_I), .EXT_DATA_LINES_O(EXT_DATA_LINES_O),
   .EXT_DATA_LINES_OE_N_O(EXT_DATA_LINES_OE_N_O),
   .EXT_ADDRESS_LINES_O(EXT_ADDRESS_LINES_O),
   .EXT_WRITE_STROBE_N_O(EXT_WRITE_STROBE_N_O),
   .EXT_READ_STROBE_N_O(EXT_READ_STROBE_N_O), .EXT_WAIT_N_I(EXT_WAIT_N_I),
   .PERIPHERAL_RESET_N_O(PERIPHERAL_RESET_N_O)
);

/* sim/byte_periph_model.sv */
// Purpose: slow byte-wide peripheral on the external bus
// Assumes: strobes and address come from controller pins
// Notes: released data lines toggle so stale data never matches
`timescale 1ns/1ps
module byte_periph_model (
   // clock and slowness
   input wire logic clk_i,
   input wire logic [3:0] slow_i,
   // bus from controller
   input wire logic [3:0] addr_i,
   input wire logic [7:0] data_i,
   input wire logic wr_n_i,
   input wire logic rd_n_i,
   // bus to controller
   output logic [7:0] data_o,
   output logic wait_n_o
);
   logic [7:0] mem [16];
   logic [3:0] held = 4'h0;
   initial begin
      for (int i = 0; i < 16; i++) begin
         mem[i] = 8'h00;
      end
      data_o = 8'h5a;
      wait_n_o = 1'b1;
   end
   always @(posedge clk_i) begin
      if (!wr_n_i) begin
         mem[addr_i] <= data_i;
      end
      data_o <= rd_n_i ? ~data_o : mem[addr_i];
      if (wr_n_i && rd_n_i) begin
         held <= 4'h0;
         wait_n_o <= 1'b1;
      end else begin
         held <= held + 4'h1;
         wait_n_o <= (held >= slow_i);
      end
   end
endmodule

/* sim/ext_byte_bus_bench.sv */
// Purpose: self-checking bench for the byte bus controller
// Assumes: 20 MHz clock; peripheral model on the pins
// Notes: driver queues expectations, a monitor compares them
`timescale 1ns/1ps
module ext_byte_bus_bench;
   import ext_bus_pkg::*;
   // ----------------
   // signals
   // ----------------
   logic clk = 1'b0, rst = 1'b1, srst = 1'b0, rwr = 1'b0, rrd = 1'b0;
   logic hreq = 1'b0, hwr = 1'b0, blank = 1'b0, ven = 1'b0, tst = 1'b0;
   logic xirq = 1'b0, busy, done, irq, oen, wrn, rdn, waitn, prstn;
   logic [1:0] hsz = 2'h0;
   logic [3:0] radr = 4'h0, hadr = 4'h0, slow = 4'h0, al;
   logic [7:0] vbyte = 8'h00, tsel = 8'h00, dlo, pd, dli;
   logic [31:0] rwd = 32'h0, hwd = 32'h0, rrd_o, hrd, msk;
   logic [7:0] mem_b [16] = '{default: 8'h00};
   logic [31:0] exp_q [$];
   logic rd_d = 1'b0, wrn_d = 1'b1, rdn_d = 1'b1;
   int err_total = 0, num_checks = 0, cyc = 0, nb = 1;
   assign dli = oen ? pd : dlo;
   always #25 clk = ~clk;
   always @(posedge clk) vbyte <= 8'($urandom);
   ext_byte_bus i_ext_byte_bus (
      .SYS_CLK_I(clk), .RST_I(rst), .SOFT_CORE_RST_I(srst),
      .REG_ADDR_I(radr), .REG_WDATA_I(rwd), .REG_WR_I(rwr), .REG_RD_I(rrd),
      .REG_RDATA_O(rrd_o), .HOST_REQ_I(hreq), .HOST_WRITE_I(hwr),
      .HOST_SIZE_I(hsz), .HOST_ADDR_I(hadr), .HOST_WDATA_I(hwd),
      .HOST_BUSY_O(busy), .HOST_DONE_O(done), .HOST_RDATA_O(hrd),
      .HOST_IRQ_O(irq), .HBLANK_PORCH_SYNC_I(blank), .VIDEO_OUT_EN_I(ven),
      .VIDEO_BYTE_I(vbyte), .FACTORY_TEST_STATE_I(tst),
      .TEST_SEL_BYTE_I(tsel), .EXT_DATA_LINES_I(dli), .EXT_DATA_LINES_O(dlo),
      .EXT_DATA_LINES_OE_N_O(oen), .EXT_ADDRESS_LINES_O(al),
      .EXT_WRITE_STROBE_N_O(wrn), .EXT_READ_STROBE_N_O(rdn),
      .EXT_WAIT_N_I(waitn), .EXT_IRQ_IN_I(xirq), .PERIPHERAL_RESET_N_O(prstn)
   );
   byte_periph_model i_byte_periph_model (
      .clk_i(clk), .slow_i(slow), .addr_i(al), .data_i(dlo), .wr_n_i(wrn),
      .rd_n_i(rdn), .data_o(pd), .wait_n_o(waitn)
   );
   // ----------------
   // checking
   // ----------------
   task automatic check(input logic [31:0] got, exp, input string what);
      num_checks++;
      if (got !== exp) begin
         err_total++;
         $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   task automatic pop(input logic [31:0] got);
      if (exp_q.size() == 0) begin
         check(32'h1, 32'h0, "unexpected result");
      end else begin
         check(got, exp_q.pop_front(), "result");
      end
   endtask
   task automatic close_out();
      $display("checks %0d errors %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   always @(negedge clk) begin
      // read data stands only in the cycle after the read strobe
      if (rd_d) pop(rrd_o);
      rd_d = rrd;
      if ((wrn_d & ~wrn) | (rdn_d & ~rdn)) begin
         pop({20'h0, al, wrn ? 8'h00 : dlo});
      end
      wrn_d = wrn;
      rdn_d = rdn;
      if (done === 1'b1 && !hwr) pop(hrd & msk);
   end
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         check(32'h1, 32'h0, "timeout");
         close_out();
      end
   end
   // ----------------
   // drivers
   // ----------------
   task automatic reg_op(input logic w, input logic [3:0] a,
                         input logic [31:0] d);
      if (!w) exp_q.push_back(d);
      @(posedge clk);
      radr <= a;
      rwd <= d;
      rwr <= w;
      rrd <= !w;
      @(posedge clk);
      rwr <= 1'b0;
      rrd <= 1'b0;
   endtask
   task automatic host_go(input logic w, input logic [1:0] sz,
                          input logic [3:0] a, input logic [31:0] d);
      logic [31:0] e;
      logic [3:0] b;
      e = 32'h0;
      nb = (sz == 2'h2) ? 4 : (sz == 2'h1) ? 2 : 1;
      msk = (nb == 4) ? 32'hffffffff : (32'h1 << (8 * nb)) - 32'h1;
      for (int i = 0; i < nb; i++) begin
         b = a + 4'(i);
         e[8*i+:8] = mem_b[b];
         if (w) mem_b[b] = d[8*i+:8];
         exp_q.push_back({20'h0, b, w ? d[8*i+:8] : 8'h00});
      end
      if (!w) exp_q.push_back(e);
      @(posedge clk);
      hreq <= 1'b1;
      hwr <= w;
      hsz <= sz;
      hadr <= a;
      hwd <= d;
      @(posedge clk);
      hreq <= 1'b0;
   endtask
   task automatic host_wait();
      for (int k = 0; k < 400; k++) begin
         @(posedge clk);
         #1;
         if (done === 1'b1) break;
      end
      check({31'h0, done}, 32'h1, "no done");
      @(posedge clk);
   endtask
   // a byte write that must stay parked while the bus is held off
   task automatic gated();
      host_go(1'b1, 2'h0, 4'h3, 32'h000000a5);
      repeat (20) begin
         @(posedge clk);
         #1;
         check({30'h0, wrn, busy}, 32'h3, "held cycle");
      end
      @(posedge clk);
   endtask
   task automatic pins(input logic [31:0] exp);
      repeat (3) @(posedge clk);
      #1;
      check({30'h0, prstn, irq}, exp, "pins");
      @(posedge clk);
   endtask
   // ----------------
   // main sequence
   // ----------------
   initial begin
      logic [3:0] a;
      void'($urandom(89));
      repeat (3) @(posedge clk);
      check({31'h0, prstn}, 32'h0, "reset out");
      rst <= 1'b0;
      for (int r = 0; r < 16; r += 4) reg_op(1'b0, 4'(r), 32'h0);
      for (int i = 0; i < 6; i++) begin
         a = (i == 5) ? 4'hf : 4'($urandom);
         slow <= (i > 2) ? 4'h3 : 4'h0;
         ven <= i[0];
         host_go(1'b1, 2'(i % 3), a, $urandom);
         host_wait();
         host_go(1'b0, 2'(i % 3), a, 32'h0);
         host_wait();
      end
      reg_op(1'b1, 4'h0, 32'h1);
      reg_op(1'b0, 4'h0, 32'h1);
      gated();
      blank <= 1'b1;
      host_wait();
      reg_op(1'b1, 4'h0, 32'h0);
      tsel <= 8'($urandom);
      tst <= 1'b1;
      gated();
      tst <= 1'b0;
      host_wait();
      reg_op(1'b1, 4'h4, 32'h1);
      xirq <= 1'b1;
      pins(32'h3);
      reg_op(1'b0, 4'h8, 32'h1);
      reg_op(1'b1, 4'h8, 32'h1);
      pins(32'h2);
      reg_op(1'b1, 4'h0, 32'h2);
      reg_op(1'b1, 4'h4, 32'h0);
      xirq <= 1'b0;
      pins(32'h2);
      reg_op(1'b0, 4'h8, 32'h1);
      reg_op(1'b1, 4'h8, 32'h1);
      reg_op(1'b1, 4'h0, 32'h4);
      pins(32'h0);
      reg_op(1'b1, 4'h0, 32'h0);
      pins(32'h2);
      srst <= 1'b1;
      @(posedge clk);
      srst <= 1'b0;
      pins(32'h2);
      repeat (4) @(posedge clk);
      check(32'(exp_q.size()), 32'h0, "left over");
      close_out();
   end
endmodule
